// *** hdl/sbc_pkg.sv ***
// Package: register map, fields, modes and states of the serial baud/clock/init block
// Contract
// - Four address interrupt conditions: ninth bit, char match, both, match after break.
// - Synchronous mode allows only the plain character-match address interrupt.
// - Clock divide select clear divides bit clock by 16; set passes it undivided.
// - Two source bits make transmit clock pin an input, generator output or serial clock.
// - External receive clock used only when its enable bit is set; software matches divide select. The generator also counts it whenever CFG_BSRC is set.
// - Baud generator is a 16-bit divide-by-N counter feeding transmitter and/or receiver.
// - Divisor zero or one halts the divider with no output transitions.
// - On initialization the divisor loads into the counter at once.
// - Generator output has a 50 percent duty cycle for even divisors; the divider holds odd divisors high one cycle longer than low.
// - Generator can count the internal core clock.
// - Writing either divisor byte disables and resets generator, transmitter and receiver.
// - Writing the second divisor byte re-enables, loads the divisor and starts counting.
// - Incoming data and receive clock are synchronized to the core clock.
// - Carrier detect gates receive clock only in synchronous mode; polarity programmable.
// - Serial data input feeds the receiver shift path through its input synchronizer.
// - Address character equal to compare register raises an address match event.
// - Address enable bit with address mode bit selects among four conditions.
// - Generator may count the external receive clock instead of core clock.
package sbc_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] ADDR_DIV_HI = 12'h000;
	localparam logic [11:0] ADDR_DIV_LO = 12'h004;
	localparam logic [11:0] ADDR_CFG    = 12'h008;
	localparam logic [11:0] ADDR_SYNC   = 12'h00C;
	localparam logic [11:0] ADDR_ACR    = 12'h010;
	localparam logic [11:0] ADDR_STAT   = 12'h014;
	// ==========================================================
	// Reset value and minimum running divisor
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] DIV_MIN  = 16'h0002;
	// ==========================================================
	// config_control_reg fields
	localparam int CFG_CD   = 0;  // clock_divide_select
	localparam int CFG_TCA  = 1;  // tx_clock_source_bit_a
	localparam int CFG_TCB  = 2;  // tx_clock_source_bit_b
	localparam int CFG_XRX  = 3;  // ext_receive_clock_enable
	localparam int CFG_AEN  = 4;  // address_irq_enable
	localparam int CFG_AMB  = 5;  // address_mode_bit
	localparam int CFG_BSRC = 6;  // generator counts external receive clock
	// sync_input_control_reg fields
	localparam int SYN_SYNC_MODE_ENABLE = 0;  // sync_mode_enable
	localparam int SYN_DPOL = 1;  // carrier detect active high when set
	// status fields
	localparam int STA_RUN  = 0;
	localparam int STA_BRG  = 1;
	localparam int STA_AMF  = 2;
	// ==========================================================
	// Bit clock prescaler in x16 mode
	localparam logic [3:0] PRE_LAST = 4'hF;
	// Synchronized input lanes
	localparam int N_SYNC  = 4;
	localparam int LN_TXC  = 0;
	localparam int LN_RXC  = 1;
	localparam int LN_DCD  = 2;
	localparam int LN_SIN  = 3;
	// ==========================================================
	// Transmit clock pin roles {bit_a, bit_b}
	typedef enum logic [1:0] {
		TCS_NONE = 2'h0,  // pin unused, generator clocks transmitter
		TCS_BRG  = 2'h1,  // pin drives generator output
		TCS_IN   = 2'h2,  // pin is transmit clock input
		TCS_SCLK = 2'h3   // pin drives serial clock
	} sbc_tcs_t;
	// Address interrupt conditions {enable, mode}
	typedef enum logic [1:0] {
		AM_NINTH = 2'h0,
		AM_MATCH = 2'h1,
		AM_BOTH  = 2'h2,
		AM_BREAK = 2'h3
	} sbc_am_t;
	// Initialization sequencer
	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN  = 3'b100
	} sbc_state_t;
endpackage

// *** hdl/sbc_baud_div.sv ***
// Baud rate generator: 16-bit divide-by-N with toggling output
`timescale 1ns/100ps
module sbc_baud_div (
	input  wire logic        core_clk,  // Core clock
	input  wire logic        rst_b,     // Async reset, active low
	input  wire logic        clr,       // Hold counter cleared
	input  wire logic        load,      // Load divisor now
	input  wire logic        cnt_en,    // Input clock enable
	input  wire logic [15:0] divisor,   // Programmed N
	output logic             brg_out,   // Generator output level
	output logic             brg_tick   // Pulse at each counted rising output, none at load
);
	import sbc_pkg::*;

	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        next_out;
	logic        next_tick;
	logic [15:0] lo_half;
	logic [15:0] hi_half;
	logic        div_ok;

	// Split the period into high and low halves
	assign lo_half = {1'b0, divisor[15:1]};
	assign hi_half = divisor - lo_half;
	assign div_ok  = (divisor >= DIV_MIN);

	// Next counter and output values
	always_comb begin
		next_cnt  = cnt;
		next_out  = brg_out;
		next_tick = 1'b0;
		if (clr) begin
			next_cnt = '0;
			next_out = 1'b0;
		end else if (load) begin
			next_cnt = hi_half;
			next_out = div_ok;
		end else if (cnt_en && div_ok) begin
			if (cnt <= 16'h0001) begin
				next_out  = ~brg_out;
				next_cnt  = brg_out ? lo_half : hi_half;
				next_tick = ~brg_out;
			end else begin
				next_cnt = cnt - 16'h0001;
			end
		end
	end

	// Register state
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt      <= '0;
			brg_out  <= 1'b0;
			brg_tick <= 1'b0;
		end else begin
			cnt      <= next_cnt;
			brg_out  <= next_out;
			brg_tick <= next_tick;
		end
	end

	// ==========================================================
	// Checks
	AST_DIV_HALT: assert property (@(posedge core_clk) disable iff (!rst_b)
		!div_ok && !load && !clr |=> $stable(brg_out))
		else $error("divider moved with divisor below two");
	AST_DIV_LOAD: assert property (@(posedge core_clk) disable iff (!rst_b)
		load && !clr |=> cnt == $past(hi_half))
		else $error("divisor not loaded on initialization");
	AST_DIV_TICK: assert property (@(posedge core_clk) disable iff (!rst_b)
		brg_tick |-> brg_out && !$past(brg_out))
		else $error("tick without rising output");
	COV_DIV_TICK: cover property (@(posedge core_clk) disable iff (!rst_b) brg_tick);
endmodule

// *** hdl/sbc_top.sv ***
// Serial clocking, baud generation, init sequencing and address event selection
`timescale 1ns/100ps
module sbc_top (
	input  wire logic        core_clk,        // Core clock, 100 MHz
	input  wire logic        rst_b,           // Async reset, active low
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB enable
	input  wire logic        pwrite,          // APB write
	input  wire logic [11:0] paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	output logic [31:0]      prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error, unmapped
	input  wire logic        ext_receive_clock_pin,  // Remote receive clock
	input  wire logic        carrier_detect_gate,    // Remote carrier detect
	input  wire logic        serial_data_input,      // Remote serial data
	input  wire logic        tx_clk_pin_in,   // Transmit clock pin level
	output logic             tx_clk_pin_out,  // Transmit clock pin drive
	output logic             tx_clk_pin_oe,   // Transmit clock pin enable
	output logic             serial_reset,    // Tx/Rx logic held in reset
	output logic             rx_shift_en,     // Receiver bit strobe
	output logic             tx_shift_en,     // Transmitter bit strobe
	output logic             rx_data_bit,     // Synchronized serial data
	input  wire logic        rx_char_valid,   // Receiver char complete
	input  wire logic [7:0]  rx_char,         // Received character
	input  wire logic        rx_ninth_bit,    // Received address bit
	input  wire logic        rx_break,        // Break detected pulse
	output logic             addr_match_evt   // Address event pulse
);
	import sbc_pkg::*;

	// ==========================================================
	// Registers and state
	logic [7:0]  div_hi, div_lo, cfg, syn, address_compare_reg;
	logic [7:0]  next_div_hi, next_div_lo, next_cfg, next_syn, next_acr;
	logic        amf, next_amf;
	sbc_state_t  state, next_state;
	logic [31:0] next_prdata;
	logic        wr_acc, rd_setup, hit, wr_div;
	logic        brg_out, brg_tick, brg_en;
	logic [N_SYNC-1:0] sync1, sync2, sync3;
	logic        rxc_rise, txc_rise, dcd_act, gate_ok, rx_src, tx_src;
	logic        sync_mode;
	sbc_tcs_t    tcs;
	logic [3:0]  rx_pre, tx_pre, next_rx_pre, next_tx_pre;
	logic        next_rx_en, next_tx_en;
	logic        brk_armed, next_brk_armed, next_evt, char_eq;
	logic        next_pin_out, next_pin_oe;
	sbc_am_t     amode;

	// ==========================================================
	// APB decode: zero-wait, one access edge
	assign pready   = 1'b1;
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign hit      = (paddr == ADDR_DIV_HI) || (paddr == ADDR_DIV_LO) ||
	                  (paddr == ADDR_CFG) || (paddr == ADDR_SYNC) ||
	                  (paddr == ADDR_ACR) || (paddr == ADDR_STAT);
	assign pslverr  = psel && penable && !hit;
	assign wr_div   = wr_acc && ((paddr == ADDR_DIV_HI) || (paddr == ADDR_DIV_LO));

	// Register writes and sticky address flag
	always_comb begin
		next_div_hi = div_hi;
		next_div_lo = div_lo;
		next_cfg    = cfg;
		next_syn    = syn;
		next_acr    = address_compare_reg;
		next_amf    = amf;
		if (wr_acc) begin
			case (paddr)
				ADDR_DIV_HI: next_div_hi = pwdata[7:0];
				ADDR_DIV_LO: next_div_lo = pwdata[7:0];
				ADDR_CFG:    next_cfg    = pwdata[7:0];
				ADDR_SYNC:   next_syn    = pwdata[7:0];
				ADDR_ACR:    next_acr    = pwdata[7:0];
				ADDR_STAT:   next_amf    = amf && !pwdata[STA_AMF];
				default:     next_amf    = amf;
			endcase
		end
		if (addr_match_evt) begin
			next_amf = 1'b1;
		end
	end

	// Read data captured in the setup cycle
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (paddr)
				ADDR_DIV_HI: next_prdata = {24'h000000, div_hi};
				ADDR_DIV_LO: next_prdata = {24'h000000, div_lo};
				ADDR_CFG:    next_prdata = {24'h000000, cfg};
				ADDR_SYNC:   next_prdata = {24'h000000, syn};
				ADDR_ACR:    next_prdata = {24'h000000, address_compare_reg};
				ADDR_STAT:   next_prdata = {29'h0000000, amf, brg_out, (state == ST_RUN)};
				default:     next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_hi <= RST_BYTE;
			div_lo <= RST_BYTE;
			cfg    <= RST_BYTE;
			syn    <= RST_BYTE;
			address_compare_reg    <= RST_BYTE;
			amf    <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			div_hi <= next_div_hi;
			div_lo <= next_div_lo;
			cfg    <= next_cfg;
			syn    <= next_syn;
			address_compare_reg    <= next_acr;
			amf    <= next_amf;
			prdata <= next_prdata;
		end
	end

	// ==========================================================
	// Initialization sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_HOLD: next_state = state;
			ST_LOAD: next_state = ST_RUN;
			ST_RUN:  next_state = state;
			default: next_state = ST_HOLD;
		endcase
		if (wr_div) begin
			next_state = ST_HOLD;
		end
		if (wr_acc && (paddr == ADDR_DIV_LO)) begin
			next_state = ST_LOAD;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	assign serial_reset = (state != ST_RUN);

	// ==========================================================
	// Input synchronizers, one lane per pin
	genvar gi;
	for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
		logic pin_raw;
		always_comb begin
			case (gi)
				LN_TXC:  pin_raw = tx_clk_pin_in;
				LN_RXC:  pin_raw = ext_receive_clock_pin;
				LN_DCD:  pin_raw = carrier_detect_gate;
				default: pin_raw = serial_data_input;
			endcase
		end
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				sync1[gi] <= 1'b0;
				sync2[gi] <= 1'b0;
				sync3[gi] <= 1'b0;
			end else begin
				sync1[gi] <= pin_raw;
				sync2[gi] <= sync1[gi];
				sync3[gi] <= sync2[gi];
			end
		end
	end

	// Edge detection and carrier gating on settled stages
	assign rxc_rise    = sync2[LN_RXC] && !sync3[LN_RXC];
	assign txc_rise    = sync2[LN_TXC] && !sync3[LN_TXC];
	assign sync_mode   = syn[SYN_SYNC_MODE_ENABLE];
	assign dcd_act     = sync2[LN_DCD] ~^ syn[SYN_DPOL];
	assign gate_ok     = !sync_mode || dcd_act;
	assign rx_data_bit = sync2[LN_SIN];
	assign tcs         = sbc_tcs_t'({cfg[CFG_TCA], cfg[CFG_TCB]});

	// ==========================================================
	// Baud generator, core clock or external receive clock
	assign brg_en = cfg[CFG_BSRC] ? rxc_rise : 1'b1;

	sbc_baud_div u_div (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clr      (state == ST_HOLD),
		.load     (state == ST_LOAD),
		.cnt_en   (brg_en && (state == ST_RUN)),
		.divisor  ({div_hi, div_lo}),
		.brg_out  (brg_out),
		.brg_tick (brg_tick)
	);

	// Bit clock sources
	assign rx_src = !serial_reset && (cfg[CFG_XRX] ? (rxc_rise && gate_ok) :
	                (brg_tick && !cfg[CFG_BSRC]));
	assign tx_src = !serial_reset && ((tcs == TCS_IN) ? txc_rise : brg_tick);

	// Prescalers: x16 with clock divide select clear, undivided when set
	always_comb begin
		next_rx_pre = rx_pre;
		next_tx_pre = tx_pre;
		next_rx_en  = 1'b0;
		next_tx_en  = 1'b0;
		if (serial_reset) begin
			next_rx_pre = '0;
			next_tx_pre = '0;
		end else begin
			if (rx_src) begin
				next_rx_pre = rx_pre + 4'h1;
				next_rx_en  = cfg[CFG_CD] || (rx_pre == PRE_LAST);
			end
			if (tx_src) begin
				next_tx_pre = tx_pre + 4'h1;
				next_tx_en  = cfg[CFG_CD] || (tx_pre == PRE_LAST);
			end
		end
	end

	// Transmit clock pin role
	always_comb begin
		case (tcs)
			TCS_BRG: begin
				next_pin_out = brg_out;
				next_pin_oe  = 1'b1;
			end
			TCS_SCLK: begin
				next_pin_out = serial_reset ? 1'b1 : brg_out;
				next_pin_oe  = 1'b1;
			end
			default: begin
				next_pin_out = 1'b0;
				next_pin_oe  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_pre         <= '0;
			tx_pre         <= '0;
			rx_shift_en    <= 1'b0;
			tx_shift_en    <= 1'b0;
			tx_clk_pin_out <= 1'b0;
			tx_clk_pin_oe  <= 1'b0;
		end else begin
			rx_pre         <= next_rx_pre;
			tx_pre         <= next_tx_pre;
			rx_shift_en    <= next_rx_en;
			tx_shift_en    <= next_tx_en;
			tx_clk_pin_out <= next_pin_out;
			tx_clk_pin_oe  <= next_pin_oe;
		end
	end

	// ==========================================================
	// Address event selection; synchronous mode forces char match
	assign amode   = sync_mode ? AM_MATCH :
	                 sbc_am_t'({cfg[CFG_AEN], cfg[CFG_AMB]});
	assign char_eq = (rx_char == address_compare_reg);

	always_comb begin
		next_brk_armed = brk_armed;
		next_evt       = 1'b0;
		if (serial_reset) begin
			next_brk_armed = 1'b0;
		end else begin
			if (rx_char_valid) begin
				case (amode)
					AM_NINTH: next_evt = rx_ninth_bit;
					AM_MATCH: next_evt = char_eq;
					AM_BOTH:  next_evt = char_eq && rx_ninth_bit;
					AM_BREAK: next_evt = char_eq && brk_armed;
					default:  next_evt = 1'b0;
				endcase
				next_brk_armed = 1'b0;
			end
			if (rx_break && !sync_mode) begin
				next_brk_armed = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			brk_armed      <= 1'b0;
			addr_match_evt <= 1'b0;
		end else begin
			brk_armed      <= next_brk_armed;
			addr_match_evt <= next_evt;
		end
	end

	// ==========================================================
	// Checks
	AST_WR_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_div |=> serial_reset)
		else $error("divisor write did not reset interface");
	AST_LO_RUN: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_acc && paddr == ADDR_DIV_LO ##1 !wr_div |=> !serial_reset)
		else $error("low byte write did not restart interface");
	AST_CD_UNDIV: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_src && cfg[CFG_CD] |=> rx_shift_en)
		else $error("undivided mode lost a bit clock");
	AST_X16: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_shift_en && !$past(cfg[CFG_CD]) |-> rx_pre == 4'h0)
		else $error("x16 strobe off the prescaler wrap");
	AST_DCD_GATE: assert property (@(posedge core_clk) disable iff (!rst_b)
		sync_mode && cfg[CFG_XRX] && !dcd_act |-> !rx_src ##1 !rx_shift_en)
		else $error("receive clock passed closed carrier gate");
	AST_TX_IN: assert property (@(posedge core_clk) disable iff (!rst_b)
		tcs == TCS_IN |=> !tx_clk_pin_oe)
		else $error("transmit clock pin driven in input role");
	AST_SYNC_MATCH: assert property (@(posedge core_clk) disable iff (!rst_b)
		sync_mode && rx_char_valid && !char_eq |=> !addr_match_evt)
		else $error("sync mode event without character match");
	AST_NINTH: assert property (@(posedge core_clk) disable iff (!rst_b)
		!serial_reset && amode == AM_NINTH && rx_char_valid && rx_ninth_bit
		|=> addr_match_evt)
		else $error("ninth bit event missed");
	AST_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b)
		addr_match_evt |=> amf)
		else $error("address flag not set");
	COV_INIT: cover property (@(posedge core_clk) disable iff (!rst_b)
		state == ST_LOAD ##1 state == ST_RUN);
	COV_EVT: cover property (@(posedge core_clk) disable iff (!rst_b) addr_match_evt);
	COV_X16: cover property (@(posedge core_clk) disable iff (!rst_b)
		rx_shift_en && !cfg[CFG_CD]);
endmodule

// *** dv/sbc_remote.sv ***
// Remote serial device: framed receive clock, carrier and data
`timescale 1ns/100ps
module sbc_remote #(
	parameter int HALF = 3  // Half clock period in core cycles
) (
	input  wire logic core_clk,  // Core clock
	input  wire logic frame_go,  // Starts one frame
	output logic      rx_clk,    // Receive clock, still between frames
	output logic      carrier,   // Carrier detect, high in frame
	output logic      sdata      // Serial data
);
	initial begin
		rx_clk = 1'b0;
		carrier = 1'b0;
		sdata = 1'b1;
	end
	// ======
	// Frame of eight clocked bits
	always @(posedge frame_go) begin
		carrier <= 1'b1;
		repeat (2) @(posedge core_clk); // Carrier leads first clock edge
		for (int i = 0; i < 8; i++) begin
			sdata <= ~sdata; // Data moves with the falling clock
			repeat (HALF) @(posedge core_clk); // Equal halves, three core periods each
			rx_clk <= 1'b1;
			repeat (HALF) @(posedge core_clk);
			rx_clk <= 1'b0;
		end
		repeat (HALF) @(posedge core_clk);
		carrier <= 1'b0;
		sdata <= ~sdata; // Released line shows the inverse
	end
endmodule

// *** dv/serial_baud_clock_init_test.sv ***
// Bench: init sequencing, baud periods, external clock and address events
`timescale 1ns/100ps
module serial_baud_clock_init_test;
	import sbc_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame_go = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic rx_char_valid = 1'b0, rx_ninth_bit = 1'b0, rx_break = 1'b0;
	logic [7:0] rx_char = 8'h00;
	logic pready, pslverr, last_err, pin_out, pin_oe, serial_reset, pin_prev;
	logic rx_shift_en, tx_shift_en, rx_data_bit, addr_match_evt, rem_clk, rem_car, rem_dat;
	int n_mismatch = 0, comparisons = 0, nr, nt, p;
	logic [23:0] pt [4] = '{24'h010002, 24'h010005, 24'h010103, 24'h000003};
	logic [31:0] ext [8] = '{32'h090004F8, 32'h090304F8, 32'h090104F0,
		32'h01000000, 32'h01000100, 32'h41000240, 32'h0B000488, 32'h0A000400};
	logic [31:0] amt [10] = '{32'h00001105, 32'h00005A00, 32'h20005A01, 32'h20005B00,
		32'h10005A00, 32'h10005A05, 32'h30005A00, 32'h30005A03, 32'h00011104, 32'h00015A01};
	`define CHECK(got, exp) \
		begin \
			comparisons++; \
			if ((got) !== (exp)) begin \
				n_mismatch++; \
				$display("Error at %0t: got %0h expected %0h", $time, got, exp); \
			end \
		end
	always #5 core_clk = ~core_clk;
	sbc_top uut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_receive_clock_pin(rem_clk), .carrier_detect_gate(rem_car),
		.serial_data_input(rem_dat), .tx_clk_pin_in(pin_oe ? pin_out : rem_clk),
		.tx_clk_pin_out(pin_out), .tx_clk_pin_oe(pin_oe), .serial_reset(serial_reset),
		.rx_shift_en(rx_shift_en), .tx_shift_en(tx_shift_en), .rx_data_bit(rx_data_bit),
		.rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_ninth_bit(rx_ninth_bit),
		.rx_break(rx_break), .addr_match_evt(addr_match_evt));
	sbc_remote #(.HALF(3)) rem (.core_clk(core_clk), .frame_go(frame_go),
		.rx_clk(rem_clk), .carrier(rem_car), .sdata(rem_dat));
	// ======
	// Bus and sequence tasks
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);  // Only the watchdog ends a stalled access
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic init(input logic [7:0] cfg, input logic [7:0] syn, input logic [15:0] dv);
		apb(1'b1, ADDR_DIV_HI, {24'h0, dv[15:8]});
		#1 `CHECK(serial_reset, 1'b1)
		apb(1'b1, ADDR_CFG, {24'h0, cfg});
		apb(1'b1, ADDR_ACR, 32'h5A);
		apb(1'b1, ADDR_SYNC, {24'h0, syn});
		apb(1'b1, ADDR_DIV_LO, {24'h0, dv[7:0]});
		#1 `CHECK(serial_reset, 1'b1)
		repeat (2) @(posedge core_clk);
		#1 `CHECK(serial_reset, 1'b0)
	endtask
	task automatic period(input int exp);
		int k;
		k = 0;
		while (tx_shift_en !== 1'b1 && k < exp + 8) begin
			@(posedge core_clk);
			k++;
		end
		`CHECK(tx_shift_en, 1'b1)
		`CHECK(k, exp + 1) // One load cycle before counting starts
		p = 0;
		do begin
			@(posedge core_clk);
			p++;
		end while (tx_shift_en !== 1'b1 && p < 2000);
		`CHECK(p, exp)
	endtask
	task automatic count(input int cyc);
		nr = 0;
		nt = 0;
		repeat (cyc) begin
			@(posedge core_clk);
			if (rx_shift_en === 1'b1) nr++;
			if (tx_shift_en === 1'b1) nt++;
		end
	endtask
	task automatic send_char(input logic [7:0] c, input logic nb, input logic brk, input logic ex);
		@(posedge core_clk);
		rx_break <= brk;
		@(posedge core_clk);
		rx_break <= 1'b0;
		rx_char_valid <= 1'b1;
		rx_char <= c;
		rx_ninth_bit <= nb;
		@(posedge core_clk);
		rx_char_valid <= 1'b0;
		#1 `CHECK(addr_match_evt, ex)
		@(posedge core_clk);
		#1 `CHECK(addr_match_evt, 1'b0)
		apb(1'b0, ADDR_STAT, 32'h0);
		`CHECK(rd[STA_AMF], ex)
		`CHECK(rd[STA_RUN], 1'b1)
		apb(1'b1, ADDR_STAT, 32'h1 << STA_AMF);
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ======
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		`CHECK(serial_reset, 1'b1) // Held until the low byte is written
		apb(1'b0, ADDR_CFG, 32'h0);
		`CHECK(rd, 32'h0) // Config reset value
		apb(1'b0, 12'h018, 32'hFF);
		`CHECK(last_err, 1'b1) // Unmapped address refused
		`CHECK(rd, 32'h0)
		foreach (pt[i]) begin
			init(pt[i][23:16], 8'h00, pt[i][15:0]);
			period(pt[i][16] ? int'(pt[i][15:0]) : 16 * int'(pt[i][15:0]));
		end
		for (int t = 0; t < 8; t += 2) begin
			init(8'(t), 8'h00, 16'h0004);
			@(posedge core_clk);
			#1 `CHECK(pin_oe, t[2])
			// Driven pin must show the divide-by-4 generator: 10 rises, 20 high in 40
			pin_prev = pin_out;
			p = 0;
			nt = 0;
			repeat (40) begin
				@(posedge core_clk);
				#1 if (pin_out === 1'b1 && pin_prev === 1'b0) p++;
				if (pin_out === 1'b1) nt++;
				pin_prev = pin_out;
			end
			`CHECK(p, t[2] ? 10 : 0)
			`CHECK(nt, t[2] ? 20 : 0)
		end
		foreach (ext[i]) begin
			init(ext[i][31:24], ext[i][23:16], {8'h00, ext[i][15:8]});
			apb(1'b0, ADDR_CFG, 32'h0);
			`CHECK(rd, {24'h0, ext[i][31:24]}) // Config reads back
			frame_go <= 1'b1;
			@(posedge core_clk);
			frame_go <= 1'b0;
			count(90);
			`CHECK(nr, int'(ext[i][3:0]))
			`CHECK(rx_data_bit, rem_dat)
			if (ext[i][7:4] != 4'hF) `CHECK(nt, int'(ext[i][7:4]))
		end
		foreach (amt[i]) begin
			init(amt[i][31:24], amt[i][23:16], 16'h0004);
			send_char(amt[i][15:8], amt[i][2], amt[i][1], amt[i][0]);
		end
		give_verdict();
	end
	// Hang guard, far beyond the expected few thousand cycles
	initial begin
		#200_000;
		n_mismatch++;
		$display("Error at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule
